/* include/sfr_pkg.sv */
// Constants, types and state records for the special-function block
// Notes on behaviour
// RULE1: Code fetch from peripherals or holes resets
// RULE2: Non-maskable events gated only by own enable
// RULE3: Unused vector slots are plain program memory
// RULE4: Unassigned special-function bits have no storage
// RULE5: Enable byte 00h: bits 0,1,4,5, cleared
// RULE6: Watchdog enable acts only in interval mode
// RULE7: Flag byte 02h: five flags, read/write
// RULE8: Power-on and power-up-clear preset chosen flags
// RULE9: Reset-mode pin event sets external-reset flag
// RULE10: Bytes 01h and 03h hold nothing
// RULE11: Timer, comparator, port flags live elsewhere
// RULE12: Fixed address decode of all regions
// RULE13: Flash takes byte and word program writes
// RULE14: Main segments 512 bytes, info 4x64
// RULE15: Mass erase main or one segment
// RULE16: Info segments alone or with main
// RULE17: Segment A locked after every reset
// RULE18: Clock sources are outside this block
// RULE19: Calibration bytes readable at 010FEh/010FFh
// RULE20: Erased reset vector sends to deepest sleep
// RULE21: Unimplemented bits read zero, writes ignored
// RULE22: Software clears flags by writing zero
package sfr_pkg;
	localparam logic [15:0] ADDR_IE0 = 16'h0000;
	localparam logic [15:0] ADDR_IE1 = 16'h0001;
	localparam logic [15:0] ADDR_IFG0 = 16'h0002;
	localparam logic [15:0] ADDR_SYSTEM_INTERRUPT_FLAGS_0 = 16'h0003;
	localparam logic [15:0] ADDR_CAL_STEP = 16'h10FE;
	localparam logic [15:0] ADDR_CAL_RANGE = 16'h10FF;
	localparam int unsigned BIT_WDT = 0;
	localparam int unsigned BIT_OSC = 1;
	localparam int unsigned BIT_POR = 2;
	localparam int unsigned BIT_RST = 3;
	localparam int unsigned BIT_NMI = 4;
	localparam int unsigned BIT_ACCV = 5;
	localparam logic [7:0] IE_MASK = 8'h33;
	localparam logic [7:0] IFG_MASK = 8'h1F;
	localparam logic [7:0] IE_RESET = 8'h00;
	localparam logic [7:0] IFG_POR_VALUE = 8'h06;
	localparam logic [7:0] IFG_PUC_SET = 8'h02;
	localparam logic [7:0] IFG_PUC_CLR = 8'h10;
	localparam logic [15:0] SFR_HI = 16'h000F;
	localparam logic [15:0] P8_HI = 16'h00FF;
	localparam logic [15:0] P16_HI = 16'h01FF;
	localparam logic [15:0] RAM_LO = 16'h0200;
	localparam logic [15:0] RAM_HI = 16'h027F;
	localparam logic [15:0] INFO_LO = 16'h1000;
	localparam logic [15:0] INFO_HI = 16'h10FF;
	localparam logic [15:0] MAIN_LO = 16'hF800;
	localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [15:0] MAIN_SEG_MASK = 16'hFE00;
	localparam logic [15:0] INFO_SEG_MASK = 16'hFFC0;
	localparam logic [15:0] SEG_A_BASE = 16'h10C0;
	localparam logic [7:0] CAL_RANGE_DEFAULT = 8'h80;
	localparam logic [7:0] CAL_STEP_DEFAULT = 8'h40;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [7:0] ZERO8 = 8'h00;

	typedef enum logic [2:0] {
		REGION_NONE,
		REGION_SFR,
		REGION_PERIPH8,
		REGION_PERIPH16,
		REGION_RAM,
		REGION_INFO,
		REGION_MAIN
	} region_t;

	typedef enum logic [1:0] {
		ERASE_SEGMENT,
		ERASE_MAIN_ALL,
		ERASE_ALL
	} erase_mode_t;

	typedef struct packed {
		logic lock_a;
		logic violation;
		logic prog;
		logic erase;
		logic byte_wr;
		logic skip_a;
		erase_mode_t mode;
		logic [15:0] addr;
		logic [15:0] data;
	} flash_state_t;
endpackage

/* include/decode_if.sv */
// Carrier between the bus front end and the address decoder
`timescale 1ns/1ps
interface decode_if;
	logic [15:0] addr;
	logic fetch;
	sfr_pkg::region_t region;
	logic fetch_fault;
	modport decoder (input addr, input fetch, output region, output fetch_fault);
	modport user (output addr, output fetch, input region, input fetch_fault);
endinterface

/* rtl/addr_decoder.sv */
// Combinational address map and illegal-fetch detection
`timescale 1ns/1ps
module addr_decoder (
	decode_if.decoder dec
);
	always_comb begin
		// RULE12: fixed region map
		if (dec.addr <= sfr_pkg::SFR_HI) begin
			dec.region = sfr_pkg::REGION_SFR;
		end else if (dec.addr <= sfr_pkg::P8_HI) begin
			dec.region = sfr_pkg::REGION_PERIPH8;
		end else if (dec.addr <= sfr_pkg::P16_HI) begin
			dec.region = sfr_pkg::REGION_PERIPH16;
		end else if (dec.addr >= sfr_pkg::RAM_LO && dec.addr <= sfr_pkg::RAM_HI) begin
			dec.region = sfr_pkg::REGION_RAM;
		end else if (dec.addr >= sfr_pkg::INFO_LO && dec.addr <= sfr_pkg::INFO_HI) begin
			dec.region = sfr_pkg::REGION_INFO;
		end else if (dec.addr >= sfr_pkg::MAIN_LO) begin
			// RULE3: spare vector slots are code
			dec.region = sfr_pkg::REGION_MAIN;
		end else begin
			dec.region = sfr_pkg::REGION_NONE;
		end
	end

	// RULE1: fetch from registers or holes
	assign dec.fetch_fault = dec.fetch && (dec.region == sfr_pkg::REGION_SFR
		|| dec.region == sfr_pkg::REGION_PERIPH8
		|| dec.region == sfr_pkg::REGION_PERIPH16
		|| dec.region == sfr_pkg::REGION_NONE);
endmodule

/* rtl/flash_ctrl.sv */
// Flash program/erase request shaping and segment A protection
`timescale 1ns/1ps
module flash_ctrl (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic puc_i,
	input wire logic prog_req_i,
	input wire logic byte_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic erase_req_i,
	input wire logic [1:0] erase_mode_i,
	input wire logic unlock_a_i,
	input wire logic lock_a_i,
	input wire logic viol_clear_i,
	output logic prog_o,
	output logic erase_o,
	output logic byte_o,
	output logic skip_a_o,
	output logic [1:0] mode_o,
	output logic [15:0] addr_o,
	output logic [15:0] data_o,
	output logic locked_a_o,
	output logic violation_o
);
	sfr_pkg::flash_state_t st_ff;
	sfr_pkg::flash_state_t nxt_st;
	logic in_seg_a;

	assign in_seg_a = (addr_i & sfr_pkg::INFO_SEG_MASK) == sfr_pkg::SEG_A_BASE;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.prog = 1'b0;
		nxt_st.erase = 1'b0;
		if (unlock_a_i) begin
			nxt_st.lock_a = 1'b0;
		end
		if (lock_a_i) begin
			nxt_st.lock_a = 1'b1;
		end
		if (viol_clear_i) begin
			nxt_st.violation = 1'b0;
		end
		if (prog_req_i) begin
			if (st_ff.lock_a && in_seg_a) begin
				nxt_st.violation = 1'b1;
			end else begin
				// RULE13: byte or word program
				nxt_st.prog = 1'b1;
				nxt_st.byte_wr = byte_i;
				nxt_st.addr = addr_i;
				nxt_st.data = byte_i ? {sfr_pkg::ZERO8, wdata_i[7:0]} : wdata_i;
			end
		end else if (erase_req_i) begin
			unique case (erase_mode_i)
				sfr_pkg::ERASE_SEGMENT: begin
					if (st_ff.lock_a && in_seg_a) begin
						nxt_st.violation = 1'b1;
					end else begin
						// RULE14: segment base by size
						nxt_st.erase = 1'b1;
						nxt_st.mode = sfr_pkg::ERASE_SEGMENT;
						nxt_st.addr = (addr_i >= sfr_pkg::MAIN_LO) ?
							(addr_i & sfr_pkg::MAIN_SEG_MASK) :
							(addr_i & sfr_pkg::INFO_SEG_MASK);
					end
				end
				sfr_pkg::ERASE_MAIN_ALL: begin
					// RULE15: all main segments
					nxt_st.erase = 1'b1;
					nxt_st.mode = sfr_pkg::ERASE_MAIN_ALL;
					nxt_st.addr = sfr_pkg::MAIN_LO;
				end
				sfr_pkg::ERASE_ALL: begin
					// RULE16: info joins main group
					nxt_st.erase = 1'b1;
					nxt_st.mode = sfr_pkg::ERASE_ALL;
					nxt_st.addr = sfr_pkg::INFO_LO;
					nxt_st.skip_a = st_ff.lock_a;
				end
				default: begin
					nxt_st.violation = 1'b1;
				end
			endcase
		end
		// RULE17: relock on every reset
		if (puc_i) begin
			nxt_st.lock_a = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '{lock_a: 1'b1, mode: sfr_pkg::ERASE_SEGMENT, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prog_o = st_ff.prog;
	assign erase_o = st_ff.erase;
	assign byte_o = st_ff.byte_wr;
	assign skip_a_o = st_ff.skip_a;
	assign mode_o = st_ff.mode;
	assign addr_o = st_ff.addr;
	assign data_o = st_ff.data;
	assign locked_a_o = st_ff.lock_a;
	assign violation_o = st_ff.violation;
endmodule

/* rtl/sfr_interrupt_bank_memmap.sv */
// Special-function bytes, system flags, address map and flash hooks
`timescale 1ns/1ps
module sfr_interrupt_bank_memmap #(
	parameter logic [7:0] CAL_RANGE = sfr_pkg::CAL_RANGE_DEFAULT,
	parameter logic [7:0] CAL_STEP = sfr_pkg::CAL_STEP_DEFAULT
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic byte_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic fetch_i,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	input wire logic power_up_clear_i,
	input wire logic wdt_event_i,
	input wire logic wdt_interval_mode_i,
	input wire logic osc_fault_i,
	input wire logic rst_nmi_pin_n_i,
	input wire logic pin_nmi_mode_i,
	input wire logic pin_nmi_falling_i,
	input wire logic flash_violation_clear_i,
	input wire logic flash_write_en_i,
	input wire logic erase_req_i,
	input wire logic [1:0] erase_mode_i,
	input wire logic seg_a_unlock_i,
	input wire logic seg_a_lock_i,
	input wire logic [15:0] reset_vector_word_i,
	output logic fetch_reset_o,
	output logic deepest_sleep_mode_o,
	output logic nmi_irq_o,
	output logic wdt_irq_o,
	output logic flash_prog_o,
	output logic flash_erase_o,
	output logic flash_byte_o,
	output logic [1:0] flash_erase_mode_o,
	output logic flash_skip_seg_a_o,
	output logic [15:0] flash_addr_o,
	output logic [15:0] flash_data_o,
	output logic seg_a_locked_o,
	output logic flash_violation_o
);
	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] ie;
		logic [7:0] ifg;
		logic [15:0] rdata;
		logic rvalid;
		logic fetch_reset;
		logic boot_pending;
		logic deep_sleep;
		logic rst_pin_q;
		logic nmi_pin_q;
		logic [1:0] osc_sync;
		logic [1:0] pin_sync;
	} top_state_t;

	top_state_t st_ff;
	top_state_t nxt_st;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;

	// RULE18: whole block on main clock
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	decode_if dec ();

	assign dec.addr = addr_i;
	assign dec.fetch = fetch_i;

	addr_decoder u_decoder (
		.dec(dec)
	);

	// ----------------------------------------
	// Flash request shaping
	// ----------------------------------------
	logic power_up_clear;
	logic prog_req;
	logic flash_viol;

	// Any clear, including the one from a bad fetch
	assign power_up_clear = power_up_clear_i || st_ff.fetch_reset;

	// RULE13: CPU writes into flash
	assign prog_req = wr_i && flash_write_en_i
		&& (dec.region == sfr_pkg::REGION_INFO
		|| dec.region == sfr_pkg::REGION_MAIN);

	flash_ctrl u_flash (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.puc_i(power_up_clear),
		.prog_req_i(prog_req),
		.byte_i(byte_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.erase_req_i(erase_req_i),
		.erase_mode_i(erase_mode_i),
		.unlock_a_i(seg_a_unlock_i),
		.lock_a_i(seg_a_lock_i),
		.viol_clear_i(flash_violation_clear_i),
		.prog_o(flash_prog_o),
		.erase_o(flash_erase_o),
		.byte_o(flash_byte_o),
		.skip_a_o(flash_skip_seg_a_o),
		.mode_o(flash_erase_mode_o),
		.addr_o(flash_addr_o),
		.data_o(flash_data_o),
		.locked_a_o(seg_a_locked_o),
		.violation_o(flash_viol)
	);

	assign flash_violation_o = flash_viol;

	// ----------------------------------------
	// Write lane selection
	// ----------------------------------------
	logic sfr_wr;
	logic wr_ie;
	logic wr_ifg;
	logic [7:0] ie_wdata;
	logic [7:0] ifg_wdata;

	assign sfr_wr = wr_i && dec.region == sfr_pkg::REGION_SFR;

	// RULE10: odd bytes map to nothing
	assign wr_ie = sfr_wr && addr_i == sfr_pkg::ADDR_IE0;
	assign wr_ifg = sfr_wr && addr_i == sfr_pkg::ADDR_IFG0;
	assign ie_wdata = wdata_i[7:0];
	assign ifg_wdata = wdata_i[7:0];

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	logic pin_n;
	logic osc_level;
	logic rst_event;
	logic nmi_event;
	logic [7:0] ifg_set;

	assign pin_n = st_ff.pin_sync[1];
	assign osc_level = st_ff.osc_sync[1];

	// RULE9: pin falling edge in reset mode
	assign rst_event = !pin_mode_nmi() && !pin_n && st_ff.rst_pin_q;

	// Selected edge while in NMI mode
	assign nmi_event = pin_mode_nmi() && (pin_nmi_falling_i ?
		(st_ff.nmi_pin_q && !pin_n) : (!st_ff.nmi_pin_q && pin_n));

	function automatic logic pin_mode_nmi();
		return pin_nmi_mode_i;
	endfunction

	// RULE11: no peripheral flags here
	always_comb begin
		ifg_set = sfr_pkg::ZERO8;
		ifg_set[sfr_pkg::BIT_WDT] = wdt_event_i;
		ifg_set[sfr_pkg::BIT_OSC] = osc_level;
		ifg_set[sfr_pkg::BIT_RST] = rst_event;
		ifg_set[sfr_pkg::BIT_NMI] = nmi_event;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.osc_sync = {st_ff.osc_sync[0], osc_fault_i};
		nxt_st.pin_sync = {st_ff.pin_sync[0], rst_nmi_pin_n_i};
		nxt_st.rst_pin_q = pin_n;
		nxt_st.nmi_pin_q = pin_n;
		nxt_st.rvalid = rd_i;

		// RULE5: enable byte write
		if (wr_ie) begin
			// RULE4: only mapped bits stored
			nxt_st.ie = ie_wdata & sfr_pkg::IE_MASK;
		end

		// RULE22: software writes zero to clear
		if (wr_ifg) begin
			// RULE7: flag byte write
			nxt_st.ifg = ifg_wdata & sfr_pkg::IFG_MASK;
		end

		// Hardware set wins over a software clear
		nxt_st.ifg = nxt_st.ifg | ifg_set;

		// RULE8: power-up clear presets
		if (power_up_clear) begin
			nxt_st.ie = sfr_pkg::IE_RESET;
			nxt_st.ifg = (nxt_st.ifg | sfr_pkg::IFG_PUC_SET) & ~sfr_pkg::IFG_PUC_CLR;
		end

		// RULE1: illegal fetch forces a clear
		nxt_st.fetch_reset = dec.fetch_fault;

		// RULE20: erased reset vector
		if (st_ff.boot_pending) begin
			nxt_st.boot_pending = 1'b0;
			nxt_st.deep_sleep = reset_vector_word_i == sfr_pkg::ERASED_WORD;
		end

		// Read data, registered
		nxt_st.rdata = sfr_pkg::ZERO16;
		if (rd_i) begin
			nxt_st.rdata = read_value(addr_i, byte_i);
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	function automatic logic [15:0] read_value(input logic [15:0] a, input logic b);
		logic [15:0] word;
		word = sfr_pkg::ZERO16;
		// RULE21: absent bits read zero
		if (a == sfr_pkg::ADDR_IE0) begin
			word = {sfr_pkg::ZERO8, st_ff.ie & sfr_pkg::IE_MASK};
		end else if (a == sfr_pkg::ADDR_IFG0) begin
			word = {sfr_pkg::ZERO8, st_ff.ifg & sfr_pkg::IFG_MASK};
		end else if (a == sfr_pkg::ADDR_CAL_STEP) begin
			// RULE19: calibration pair
			word = b ? {sfr_pkg::ZERO8, CAL_STEP} : {CAL_RANGE, CAL_STEP};
		end else if (a == sfr_pkg::ADDR_CAL_RANGE) begin
			word = {sfr_pkg::ZERO8, CAL_RANGE};
		end else begin
			// RULE10: 01h and 03h read zero
			word = sfr_pkg::ZERO16;
		end
		if (b) begin
			word = {sfr_pkg::ZERO8, word[7:0]};
		end
		return word;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			// RULE8: power-on values
			st_ff <= '{
				ie: sfr_pkg::IE_RESET,
				ifg: sfr_pkg::IFG_POR_VALUE,
				boot_pending: 1'b1,
				rst_pin_q: 1'b1,
				nmi_pin_q: 1'b1,
				pin_sync: 2'h3,
				default: '0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Interrupt requests
	// ----------------------------------------
	logic nmi_osc;
	logic nmi_pin;
	logic nmi_flash;

	// RULE2: own enables only, no global gate
	assign nmi_osc = st_ff.ifg[sfr_pkg::BIT_OSC] && st_ff.ie[sfr_pkg::BIT_OSC];
	assign nmi_pin = st_ff.ifg[sfr_pkg::BIT_NMI] && st_ff.ie[sfr_pkg::BIT_NMI];
	assign nmi_flash = flash_viol && st_ff.ie[sfr_pkg::BIT_ACCV];
	assign nmi_irq_o = nmi_osc || nmi_pin || nmi_flash;

	// RULE6: enable used in interval mode only
	assign wdt_irq_o = wdt_interval_mode_i
		&& st_ff.ifg[sfr_pkg::BIT_WDT]
		&& st_ff.ie[sfr_pkg::BIT_WDT];

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o = st_ff.rdata;
	assign rvalid_o = st_ff.rvalid;
	assign fetch_reset_o = st_ff.fetch_reset;
	assign deepest_sleep_mode_o = st_ff.deep_sleep;
endmodule

/* tb/sfr_sva.sv */
// Port-level checker for the special-function block
`timescale 1ns/1ps
module sfr_sva #(
	parameter logic [7:0] CAL_RANGE = 8'h80,
	parameter logic [7:0] CAL_STEP = 8'h40
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [15:0] addr_i,
	input wire logic byte_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic fetch_i,
	input wire logic [15:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic wdt_interval_mode_i,
	input wire logic flash_write_en_i,
	input wire logic erase_req_i,
	input wire logic [15:0] reset_vector_word_i,
	input wire logic fetch_reset_o,
	input wire logic deepest_sleep_mode_o,
	input wire logic wdt_irq_o,
	input wire logic flash_prog_o,
	input wire logic [15:0] flash_addr_o,
	input wire logic flash_byte_o,
	input wire logic seg_a_locked_o
);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	bad_fetch_a: assert property (fetch_i && addr_i <= 16'h01FF |=>
		fetch_reset_o ##1 !fetch_reset_o) else $error("illegal fetch not reset");
	vector_code_a: assert property (fetch_i && addr_i >= 16'hF800 |=>
		!fetch_reset_o) else $error("legal fetch reset");
	read_answer_a: assert property (rd_i |=> rvalid_o) else $error("no read answer");
	idle_data_a: assert property (!rvalid_o |-> rdata_o == 16'h0000)
		else $error("data while idle");
	reserved_zero_a: assert property (rd_i && (addr_i == 16'h0001 || addr_i == 16'h0003)
		|=> rdata_o == 16'h0000) else $error("reserved byte nonzero");
	enable_bits_a: assert property (rd_i && addr_i == 16'h0000
		|=> (rdata_o & 16'hFFCC) == 16'h0000) else $error("enable spare bit");
	flag_bits_a: assert property (rd_i && addr_i == 16'h0002
		|=> (rdata_o & 16'hFFE0) == 16'h0000) else $error("flag spare bit");
	cal_word_a: assert property (rd_i && !byte_i && addr_i == 16'h10FE
		|=> rdata_o == {CAL_RANGE, CAL_STEP}) else $error("calibration word");
	wdt_gate_a: assert property (!wdt_interval_mode_i |-> !wdt_irq_o)
		else $error("watchdog irq in watchdog mode");
	sleep_load_a: assert property ($rose(deepest_sleep_mode_o)
		|-> $past(reset_vector_word_i) == 16'hFFFF) else $error("sleep without erased vector");
	prog_pass_a: assert property (wr_i && flash_write_en_i && addr_i >= 16'hF800 && !erase_req_i
		|=> flash_prog_o && flash_addr_o == $past(addr_i) && flash_byte_o == $past(byte_i))
		else $error("program not passed");
	seg_a_guard_a: assert property (wr_i && flash_write_en_i && addr_i[15:6] == 10'h043
		&& seg_a_locked_o |=> !flash_prog_o) else $error("locked segment programmed");
	fetch_c: cover property (fetch_reset_o);
	prog_c: cover property (flash_prog_o);
	sleep_c: cover property (deepest_sleep_mode_o);
endmodule
bind sfr_interrupt_bank_memmap sfr_sva #(.CAL_RANGE(CAL_RANGE), .CAL_STEP(CAL_STEP)) chk (.*);

/* tb/cpu_model.sv */
// Behavioural CPU on the memory-mapped bus
`timescale 1ns/1ps
module cpu_model (
	input wire logic clk_i,
	output logic [15:0] addr_o,
	output logic [15:0] wdata_o,
	output logic byte_o,
	output logic wr_o,
	output logic rd_o,
	output logic fetch_o
);
	initial {addr_o, wdata_o, byte_o, wr_o, rd_o, fetch_o} = '0;
	task automatic cyc(input logic w, r, f, b, input logic [15:0] a, d);
		@(negedge clk_i);
		{wr_o, rd_o, fetch_o, byte_o, addr_o, wdata_o} = {w, r, f, b, a, d};
		@(negedge clk_i);
		{wr_o, rd_o, fetch_o} = 3'h0;
		// Released address and data lines show no stale value
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask
endmodule

/* tb/sfr_interrupt_bank_memmap_tb.sv */
// Self-checking bench for the special-function block
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
	cmp_count++; \
	if ((s) !== (e)) begin \
		mismatches++; \
		$display("unexpected %s exp %h got %h", n, e, s); \
	end \
end
module sfr_interrupt_bank_memmap_tb;
	logic clk_i = 1'b0;
	logic reset_n_i, power_up_clear_i, wdt_event_i, wdt_interval_mode_i, osc_fault_i;
	logic rst_nmi_pin_n_i, pin_nmi_mode_i, pin_nmi_falling_i, flash_violation_clear_i;
	logic flash_write_en_i, erase_req_i, seg_a_unlock_i, seg_a_lock_i;
	logic byte_i, wr_i, rd_i, fetch_i, rvalid_o, fetch_reset_o, deepest_sleep_mode_o;
	logic nmi_irq_o, wdt_irq_o, flash_prog_o, flash_erase_o, flash_byte_o;
	logic flash_skip_seg_a_o, seg_a_locked_o, flash_violation_o;
	logic [1:0] erase_mode_i, flash_erase_mode_o;
	logic [15:0] addr_i, wdata_i, rdata_o, reset_vector_word_i, flash_addr_o, flash_data_o;
	int mismatches = 0;
	int cmp_count = 0;
	// ----------------------------------------
	// Clock, parts and helpers
	// ----------------------------------------
	always #2 clk_i = ~clk_i;
	sfr_interrupt_bank_memmap dut (.*);
	cpu_model cpu (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .byte_o(byte_i),
		.wr_o(wr_i), .rd_o(rd_i), .fetch_o(fetch_i));
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic wr(input logic [15:0] a, d);
		cpu.cyc(1'b1, 1'b0, 1'b0, 1'b1, a, d);
	endtask
	task automatic chk_rd(input logic b, input logic [15:0] a, e, input string n);
		cpu.cyc(1'b0, 1'b1, 1'b0, b, a, 16'h0000);
		`CHK(n, e, rdata_o)
	endtask
	task automatic erase(input logic [1:0] m, input logic [15:0] a);
		erase_mode_i = m;
		fork
			cpu.cyc(1'b0, 1'b0, 1'b0, 1'b0, a, 16'h0000);
			begin
				@(negedge clk_i);
				erase_req_i = 1'b1;
				@(negedge clk_i);
				erase_req_i = 1'b0;
			end
		join
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic do_reset(input logic [15:0] vec, input logic sleep);
		reset_n_i = 1'b0;
		reset_vector_word_i = vec;
		tick(4);
		reset_n_i = 1'b1;
		tick(6);
		`CHK("sleep", sleep, deepest_sleep_mode_o)
		`CHK("lock_a", 1'b1, seg_a_locked_o)
		chk_rd(1'b1, 16'h0000, 16'h0000, "ie reset");
		chk_rd(1'b1, 16'h0002, 16'h0006, "flags reset");
		$display("reset test done");
	endtask
	task automatic t_regs();
		wr(16'h0000, 16'h00FF);
		chk_rd(1'b1, 16'h0000, 16'h0033, "ie bits");
		wr(16'h0001, 16'h00FF);
		wr(16'h0003, 16'h00FF);
		chk_rd(1'b1, 16'h0001, 16'h0000, "ie1");
		chk_rd(1'b1, 16'h0003, 16'h0000, "system_interrupt_flags_0");
		wr(16'h0002, 16'h00FF);
		chk_rd(1'b1, 16'h0002, 16'h001F, "flag bits");
		wr(16'h10FF, 16'h0000);
		chk_rd(1'b0, 16'h10FE, 16'h8040, "cal word");
		chk_rd(1'b1, 16'h10FF, 16'h0080, "cal range");
		wr(16'h0000, 16'h0000);
		wr(16'h0002, 16'h0000);
		chk_rd(1'b1, 16'h0002, 16'h0000, "flags clear");
		$display("register test done");
	endtask
	task automatic t_irq();
		wr(16'h0000, 16'h0003);
		`CHK("nmi idle", 1'b0, nmi_irq_o)
		osc_fault_i = 1'b1;
		tick(5);
		osc_fault_i = 1'b0;
		`CHK("nmi osc", 1'b1, nmi_irq_o)
		wdt_event_i = 1'b1;
		tick(1);
		wdt_event_i = 1'b0;
		tick(1);
		`CHK("wdt gated", 1'b0, wdt_irq_o)
		wdt_interval_mode_i = 1'b1;
		tick(1);
		`CHK("wdt interval", 1'b1, wdt_irq_o)
		wdt_interval_mode_i = 1'b0;
		rst_nmi_pin_n_i = 1'b0;
		tick(6);
		rst_nmi_pin_n_i = 1'b1;
		tick(4);
		chk_rd(1'b1, 16'h0002, 16'h000B, "pin reset");
		wr(16'h0002, 16'h0000);
		wr(16'h0000, 16'h0010);
		pin_nmi_mode_i = 1'b1;
		tick(4);
		rst_nmi_pin_n_i = 1'b0;
		tick(6);
		`CHK("nmi pin", 1'b1, nmi_irq_o)
		rst_nmi_pin_n_i = 1'b1;
		tick(4);
		chk_rd(1'b1, 16'h0002, 16'h0010, "pin nmi");
		wr(16'h0002, 16'h0000);
		pin_nmi_falling_i = 1'b0;
		rst_nmi_pin_n_i = 1'b0;
		tick(6);
		`CHK("nmi rise wait", 1'b0, nmi_irq_o)
		rst_nmi_pin_n_i = 1'b1;
		tick(4);
		chk_rd(1'b1, 16'h0002, 16'h0010, "pin nmi rise");
		pin_nmi_falling_i = 1'b1;
		pin_nmi_mode_i = 1'b0;
		$display("interrupt test done");
	endtask
	task automatic t_fetch();
		logic [15:0] fa [6];
		logic fe [6];
		fa = '{16'h0100, 16'h0300, 16'h1100, 16'h0200, 16'hFFC0, 16'h1000};
		fe = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		wr(16'h0000, 16'h0033);
		for (int i = 0; i < 6; i++) begin
			cpu.cyc(1'b0, 1'b0, 1'b1, 1'b0, fa[i], 16'h0000);
			`CHK("fetch reset", fe[i], fetch_reset_o)
		end
		chk_rd(1'b1, 16'h0000, 16'h0000, "ie puc");
		chk_rd(1'b1, 16'h0002, 16'h0002, "flags puc");
		$display("fetch test done");
	endtask
	task automatic t_flash();
		flash_write_en_i = 1'b1;
		cpu.cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'hF802, 16'h1234);
		`CHK("prog data", 17'h11234, {flash_prog_o, flash_data_o})
		cpu.cyc(1'b1, 1'b0, 1'b0, 1'b1, 16'hF803, 16'h0056);
		`CHK("prog byte", 2'h3, {flash_prog_o, flash_byte_o})
		cpu.cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'h10C2, 16'hABCD);
		`CHK("locked prog", 2'h1, {flash_prog_o, flash_violation_o})
		flash_violation_clear_i = 1'b1;
		seg_a_unlock_i = 1'b1;
		tick(1);
		{flash_violation_clear_i, seg_a_unlock_i} = 2'h0;
		tick(1);
		`CHK("unlock", 2'h0, {seg_a_locked_o, flash_violation_o})
		cpu.cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'h10C2, 16'hABCD);
		`CHK("open prog", 1'b1, flash_prog_o)
		flash_write_en_i = 1'b0;
		erase(2'h0, 16'hF9FF);
		`CHK("seg main", 19'h4F800, {flash_erase_o, flash_erase_mode_o, flash_addr_o})
		erase(2'h0, 16'h1045);
		`CHK("seg info", 19'h41040, {flash_erase_o, flash_erase_mode_o, flash_addr_o})
		erase(2'h1, 16'hF800);
		`CHK("main all", 3'h5, {flash_erase_o, flash_erase_mode_o})
		erase(2'h2, 16'hF800);
		`CHK("all open", 4'hC, {flash_erase_o, flash_erase_mode_o, flash_skip_seg_a_o})
		seg_a_lock_i = 1'b1;
		tick(1);
		seg_a_lock_i = 1'b0;
		erase(2'h2, 16'hF800);
		`CHK("all locked", 4'hD, {flash_erase_o, flash_erase_mode_o, flash_skip_seg_a_o})
		erase(2'h3, 16'hF800);
		`CHK("bad mode", 2'h1, {flash_erase_o, flash_violation_o})
		wr(16'h0000, 16'h0033);
		wr(16'h0002, 16'h001D);
		seg_a_unlock_i = 1'b1;
		tick(1);
		seg_a_unlock_i = 1'b0;
		power_up_clear_i = 1'b1;
		tick(1);
		power_up_clear_i = 1'b0;
		`CHK("puc relock", 1'b1, seg_a_locked_o)
		chk_rd(1'b1, 16'h0000, 16'h0000, "ie pin puc");
		chk_rd(1'b1, 16'h0002, 16'h000F, "flags pin puc");
		$display("flash test done");
	endtask
	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		{power_up_clear_i, wdt_event_i, wdt_interval_mode_i, osc_fault_i, pin_nmi_mode_i} = '0;
		{flash_violation_clear_i, flash_write_en_i, erase_req_i, seg_a_unlock_i} = '0;
		{seg_a_lock_i, erase_mode_i} = '0;
		{rst_nmi_pin_n_i, pin_nmi_falling_i} = 2'h3;
		do_reset(16'hFFFF, 1'b1);
		t_regs();
		t_irq();
		t_fetch();
		t_flash();
		do_reset(16'h1234, 1'b0);
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		end_of_test();
	end
endmodule
